// file: hdl/fsps_host.sv
// fsps_host: boot-loader side sequencer driven by software registers
// assumes software owns the page data register and reads results a cycle later
`timescale 1ns/1ns
module fsps_host import fsps_pkg::*; #(
	parameter int PAGE_WORDS = 16 // words per page
) (
	input wire logic clock, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic [3:0] addr, // register address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [15:0] rdata, // read data, cycle after rd
	output logic irq, // level interrupt
	fsps_if.host link // device side
);
	fsps_hstate_e st_r;
	logic [7:0] cmd_r, phase_r, ctl_val_r, rbyte_r, mask_r;
	logic [15:0] zp_r, data_r;
	logic [2:0] sts_r;
	logic [6:0] cnt_r;
	logic done_ev, err_ev;

	assign link.zptr = zp_r;
	assign link.r10 = data_r;
	assign link.ctl_wr = st_r == FSPS_H_WRCTL;
	assign link.ctl_wdata = ctl_val_r;
	assign link.spm = st_r == FSPS_H_ISSUE && !ctl_val_r[SIG_RD_BIT];
	assign link.lpm = (st_r == FSPS_H_ISSUE && ctl_val_r[SIG_RD_BIT]) || st_r == FSPS_H_VERIFY;
	assign irq = |(sts_r & mask_r[2:0]);
	// update is done once the whole page has read back clean
	assign done_ev = st_r == FSPS_H_VCHK && !err_ev && cnt_r == 7'(2 * PAGE_WORDS - 1);
	assign err_ev = st_r == FSPS_H_VCHK && link.lpm_data != data_r[7:0];

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= FSPS_H_IDLE;
			cmd_r <= 8'h00;
			phase_r <= 8'h00;
			ctl_val_r <= 8'h00;
			zp_r <= 16'h0000;
			cnt_r <= 7'h00;
			rbyte_r <= 8'h00;
		end else begin
			case (st_r)
				FSPS_H_IDLE: begin
					if (wr && addr == HREG_CMD) begin
						cmd_r <= wdata[7:0];
						phase_r <= 8'h00;
						st_r <= FSPS_H_POLL;
					end
				end
				FSPS_H_POLL: begin
					if (!link.ctl_rdata[SPM_EN_BIT]) st_r <= FSPS_H_EEWAIT;
				end
				FSPS_H_EEWAIT: begin
					if (!link.ee_busy) st_r <= FSPS_H_WRCTL;
					case (cmd_r)
						HCMD_SIG: ctl_val_r <= 8'h21;
						HCMD_LOCK: ctl_val_r <= 8'h09;
						HCMD_UPDATE: begin
							case (phase_r)
								8'h00: ctl_val_r <= 8'h03;
								8'h01, 8'h04: ctl_val_r <= 8'h11;
								8'h02: ctl_val_r <= 8'h01;
								8'h03: ctl_val_r <= 8'h05;
								default: ctl_val_r <= 8'h11;
							endcase
						end
						default: st_r <= FSPS_H_IDLE;
					endcase
				end
				FSPS_H_WRCTL: st_r <= FSPS_H_ISSUE;
				FSPS_H_ISSUE: st_r <= FSPS_H_NEXT;
				FSPS_H_NEXT: begin
					if (cmd_r != HCMD_UPDATE) begin
						rbyte_r <= link.lpm_data;
						st_r <= FSPS_H_IDLE;
					end else if (phase_r == 8'h02 && cnt_r != 7'(PAGE_WORDS - 1)) begin
						cnt_r <= cnt_r + 7'h1;
						zp_r <= zp_r + 16'h0002;
						st_r <= FSPS_H_LOAD;
					end else if (phase_r == 8'h04) begin
						st_r <= FSPS_H_RWCHK;
					end else begin
						if (phase_r == 8'h02) zp_r <= zp_r - 16'(2 * (PAGE_WORDS - 1));
						cnt_r <= 7'h00;
						phase_r <= phase_r + 8'h01;
						st_r <= FSPS_H_POLL;
					end
				end
				FSPS_H_LOAD: begin
					if (wr && addr == HREG_DATA) st_r <= FSPS_H_POLL;
				end
				FSPS_H_RWCHK: begin
					if (!link.ctl_rdata[RWW_BUSY_BIT]) st_r <= FSPS_H_VERIFY;
					else begin
						phase_r <= 8'h04;
						st_r <= FSPS_H_POLL;
					end
				end
				FSPS_H_VERIFY: st_r <= FSPS_H_VCHK;
				FSPS_H_VCHK: begin
					if (err_ev || cnt_r == 7'(2 * PAGE_WORDS - 1)) st_r <= FSPS_H_IDLE;
					else begin
						cnt_r <= cnt_r + 7'h1;
						zp_r <= zp_r + 16'h0001;
						st_r <= FSPS_H_VERIFY;
					end
				end
				default: st_r <= FSPS_H_IDLE;
			endcase
			if (wr && addr == HREG_ADDR && st_r == FSPS_H_IDLE) zp_r <= wdata;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) data_r <= 16'h0000;
		else if (wr && addr == HREG_DATA) data_r <= wdata;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sts_r <= 3'h0;
			mask_r <= 8'h00;
		end else begin
			if (wr && addr == HREG_IRQ) sts_r <= sts_r & ~wdata[2:0];
			if (done_ev) sts_r[0] <= 1'b1;
			if (err_ev) sts_r[1] <= 1'b1;
			if (st_r == FSPS_H_NEXT && cmd_r != HCMD_UPDATE) sts_r[2] <= 1'b1;
			if (wr && addr == HREG_MASK) mask_r <= wdata[7:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) rdata <= 16'h0000;
		else if (rd) begin
			case (addr)
				HREG_ADDR: rdata <= zp_r;
				HREG_DATA: rdata <= data_r;
				HREG_STAT: rdata <= {4'h0, st_r, link.ctl_rdata};
				HREG_IRQ: rdata <= {13'h0000, sts_r};
				HREG_MASK: rdata <= {8'h00, mask_r};
				HREG_RDATA: rdata <= {8'h00, rbyte_r};
				default: rdata <= 16'h0000;
			endcase
		end else rdata <= 16'h0000;
	end
endmodule

// file: hdl/fsps_pkg.sv
// fsps_pkg: shared constants for the flash self-programming sequencer pair
// assumes a 10 MHz system clock shared by both ends
package fsps_pkg;
	localparam int CLK_HZ = 10_000_000;
	// flash operation window in nanoseconds
	localparam int PROG_MIN_NS = 3_200_000;
	localparam int PROG_MAX_NS = 3_400_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int PROG_MIN_CYC = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_MAX_CYC = PROG_MAX_NS / CLK_NS;
	// cycles the arming bits wait for a load or store
	localparam logic [1:0] LOAD_WINDOW = 2'h3;
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	// store-program control register bit positions
	localparam int SPM_EN_BIT = 0;
	localparam int PG_ERASE_BIT = 1;
	localparam int PG_WRITE_BIT = 2;
	localparam int LOCK_SET_BIT = 3;
	localparam int RWW_REEN_BIT = 4;
	localparam int SIG_RD_BIT = 5;
	localparam int RWW_BUSY_BIT = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// signature row pointer addresses
	localparam logic [15:0] SIG_DEV0 = 16'h0000;
	localparam logic [15:0] SIG_CAL = 16'h0001;
	localparam logic [15:0] SIG_DEV1 = 16'h0002;
	localparam logic [15:0] SIG_DEV2 = 16'h0004;
	localparam logic [15:0] SIG_SN1 = 16'h000E;
	localparam logic [15:0] SIG_SN0 = 16'h000F;
	localparam logic [15:0] SIG_SN3 = 16'h0010;
	localparam logic [15:0] SIG_SN2 = 16'h0011;
	localparam logic [15:0] SIG_SN5 = 16'h0012;
	localparam logic [15:0] SIG_SN4 = 16'h0013;
	localparam logic [15:0] SIG_SN6 = 16'h0015;
	localparam logic [15:0] SIG_SN7 = 16'h0016;
	localparam logic [15:0] SIG_SN8 = 16'h0017;
	// host software registers
	localparam logic [3:0] HREG_CMD = 4'h0;
	localparam logic [3:0] HREG_ADDR = 4'h1;
	localparam logic [3:0] HREG_DATA = 4'h2;
	localparam logic [3:0] HREG_STAT = 4'h3;
	localparam logic [3:0] HREG_IRQ = 4'h4;
	localparam logic [3:0] HREG_MASK = 4'h5;
	localparam logic [3:0] HREG_RDATA = 4'h6;
	// host command codes
	localparam logic [7:0] HCMD_SIG = 8'h01;
	localparam logic [7:0] HCMD_UPDATE = 8'h02;
	localparam logic [7:0] HCMD_LOCK = 8'h03;
	typedef enum logic [3:0] {
		FSPS_H_IDLE = 4'b0000,
		FSPS_H_POLL = 4'b0001,
		FSPS_H_EEWAIT = 4'b0010,
		FSPS_H_WRCTL = 4'b0011,
		FSPS_H_ISSUE = 4'b0100,
		FSPS_H_LOAD = 4'b0101,
		FSPS_H_NEXT = 4'b0110,
		FSPS_H_VERIFY = 4'b0111,
		FSPS_H_VCHK = 4'b1000,
		FSPS_H_RWCHK = 4'b1001
	} fsps_hstate_e;
endpackage

// file: hdl/fsps_if.sv
// fsps_if: the CPU-core-to-flash-controller link
// assumes both ends share clock and reset_n
`timescale 1ns/1ns
interface fsps_if;
	logic ctl_wr; // write store-program control register
	logic [7:0] ctl_wdata; // control write data
	logic [7:0] ctl_rdata; // control register readback
	logic [15:0] zptr; // address pointer
	logic [15:0] r10; // store data word
	logic spm; // store-program instruction strobe
	logic lpm; // program-memory load strobe
	logic [7:0] lpm_data; // load result, valid cycle after lpm
	logic lpm_blocked; // load hit busy section
	logic ee_busy; // eeprom_write_active level
	modport dev (input ctl_wr, ctl_wdata, zptr, r10, spm, lpm,
		output ctl_rdata, lpm_data, lpm_blocked, ee_busy);
	modport host (output ctl_wr, ctl_wdata, zptr, r10, spm, lpm,
		input ctl_rdata, lpm_data, lpm_blocked, ee_busy);
endinterface

// file: hdl/fsps_dev.sv
// fsps_dev: flash controller end: control register, signature reads, op timer
// assumes the host keeps the spm/lpm timing windows; flash array is modelled small
`timescale 1ns/1ns
module fsps_dev import fsps_pkg::*; #(
	parameter int PROG_CYC = PROG_MIN_CYC + 1000, // within min..max window
	parameter int AW = 8, // flash word address bits modelled
	parameter int NO_READ_WHILE_WRITE_SECTION_BASE = 192, // first word of no-read-while-write section
	parameter int PAGE_W = 4, // word bits inside a page
	parameter logic [7:0] DEV_ID0 = 8'h11, // arbitrary
	parameter logic [7:0] DEV_ID1 = 8'h22, // arbitrary
	parameter logic [7:0] DEV_ID2 = 8'h33, // arbitrary
	parameter logic [7:0] CAL_BYTE = 8'h80, // calibration value
	parameter logic [71:0] SERIAL = 72'h0123456789ABCDEF01 // arbitrary
) (
	input wire logic clock, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic osc_tick, // calibrated rc oscillator tick
	input wire logic ee_write_active, // eeprom write in progress
	fsps_if.dev link, // cpu side
	output logic flash_busy, // operation in progress
	output logic [7:0] lock_bits // stored lock byte
);
	logic [7:0] ctl_r;
	logic [2:0] win_r;
	logic [15:0] mem_r [0:(1<<AW)-1];
	logic [15:0] buf_r [0:(1<<PAGE_W)-1];
	logic [1:0] op_r; // 1 erase 2 write 3 lock
	logic [AW-1:0] op_page_r;
	logic [7:0] op_lock_r;
	logic [31:0] tmr_r;
	logic [7:0] lpm_data_r;
	logic blk_r;
	logic [7:0] sig_byte;
	logic [AW-1:0] waddr;
	logic rww_hit;
	logic armed_sig;

	assign waddr = link.zptr[AW:1];
	assign rww_hit = int'(waddr) < NO_READ_WHILE_WRITE_SECTION_BASE;
	assign armed_sig = ctl_r[SIG_RD_BIT] && ctl_r[SPM_EN_BIT];
	assign flash_busy = op_r != 2'h0;
	assign link.ctl_rdata = ctl_r;
	assign link.lpm_data = lpm_data_r;
	assign link.lpm_blocked = blk_r;
	assign link.ee_busy = ee_write_active;

	// signature row decode
	always_comb begin
		case (link.zptr)
			SIG_DEV0: sig_byte = DEV_ID0;
			SIG_DEV1: sig_byte = DEV_ID1;
			SIG_DEV2: sig_byte = DEV_ID2;
			SIG_CAL: sig_byte = CAL_BYTE;
			SIG_SN1: sig_byte = SERIAL[15:8];
			SIG_SN0: sig_byte = SERIAL[7:0];
			SIG_SN3: sig_byte = SERIAL[31:24];
			SIG_SN2: sig_byte = SERIAL[23:16];
			SIG_SN5: sig_byte = SERIAL[47:40];
			SIG_SN4: sig_byte = SERIAL[39:32];
			SIG_SN6: sig_byte = SERIAL[55:48];
			SIG_SN7: sig_byte = SERIAL[63:56];
			SIG_SN8: sig_byte = SERIAL[71:64];
			default: sig_byte = 8'hFF;
		endcase
	end

	// control register with self-clearing arming window
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctl_r <= CTRL_RESET;
			win_r <= 3'h0;
		end else if (link.ctl_wr && !ee_write_active && !flash_busy) begin
			ctl_r <= {1'b0, link.ctl_wdata[6:0]};
			win_r <= link.ctl_wdata[SIG_RD_BIT] ? {1'b0, LOAD_WINDOW} : STORE_WINDOW;
		end else begin
			ctl_r[RWW_BUSY_BIT] <= ctl_r[RWW_BUSY_BIT] || flash_busy;
			if (ctl_r[SPM_EN_BIT]) begin
				if ((armed_sig && link.lpm) || (win_r == 3'h0 && !flash_busy)) begin
					ctl_r[5:0] <= 6'h00;
				end else if (link.spm && !armed_sig) begin
					if (ctl_r[RWW_REEN_BIT] && !flash_busy) begin
						ctl_r[RWW_BUSY_BIT] <= 1'b0;
					end
					if (!(ctl_r[PG_ERASE_BIT] || ctl_r[PG_WRITE_BIT] || ctl_r[LOCK_SET_BIT])) begin
						ctl_r[5:0] <= 6'h00;
					end
					win_r <= 3'h0;
				end else if (win_r != 3'h0) begin
					win_r <= win_r - 3'h1;
				end
				if (op_r != 2'h0 && tmr_r == 32'h1 && osc_tick) begin
					ctl_r[5:0] <= 6'h00;
				end
			end
		end
	end

	// flash operation timer on the oscillator tick; reset does not abort it
	always_ff @(posedge clock) begin
		if (op_r == 2'h0) begin
			if (reset_n && link.spm && ctl_r[SPM_EN_BIT] && !armed_sig && win_r != 3'h0) begin
				tmr_r <= 32'(PROG_CYC);
				op_page_r <= waddr >> PAGE_W;
				op_lock_r <= link.r10[7:0];
				if (ctl_r[PG_ERASE_BIT]) op_r <= 2'h1;
				else if (ctl_r[PG_WRITE_BIT]) op_r <= 2'h2;
				else if (ctl_r[LOCK_SET_BIT]) op_r <= 2'h3;
				else op_r <= 2'h0;
			end
		end else if (osc_tick) begin
			tmr_r <= tmr_r - 32'h1;
			if (tmr_r == 32'h1) begin
				op_r <= 2'h0;
			end
		end
	end

	// array and page buffer
	always_ff @(posedge clock) begin
		if (op_r != 2'h0 && osc_tick && tmr_r == 32'h1) begin
			for (int i = 0; i < (1 << PAGE_W); i++) begin
				if (op_r == 2'h1) mem_r[{op_page_r[AW-1-PAGE_W:0], PAGE_W'(i)}] <= 16'hFFFF;
				if (op_r == 2'h2) mem_r[{op_page_r[AW-1-PAGE_W:0], PAGE_W'(i)}] <= buf_r[i];
			end
			if (op_r == 2'h3) lock_bits <= op_lock_r;
		end
		if (reset_n && link.spm && ctl_r == 8'h01 && win_r != 3'h0) begin
			buf_r[waddr[PAGE_W-1:0]] <= link.r10;
		end
	end

	// program-memory load path
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lpm_data_r <= 8'h00;
			blk_r <= 1'b0;
		end else if (link.lpm) begin
			blk_r <= 1'b0;
			if (armed_sig) begin
				lpm_data_r <= sig_byte;
			end else if (rww_hit && ctl_r[RWW_BUSY_BIT]) begin
				lpm_data_r <= 8'hFF;
				blk_r <= 1'b1;
			end else begin
				lpm_data_r <= link.zptr[0] ? mem_r[waddr][15:8] : mem_r[waddr][7:0];
			end
		end
	end
endmodule

// file: sim/fsps_properties.sv
// fsps_properties: assertions on the link between the two ends
// assumes one clock domain and the oscillator tick tied high
`timescale 1ns/1ns
module fsps_properties import fsps_pkg::*; #(
	parameter int PROG_CYC = 20, // op length in ticks
	parameter logic [7:0] DEV_ID0 = 8'h00, // device byte 0
	parameter logic [7:0] CAL_BYTE = 8'h00, // calibration byte
	parameter logic [71:0] SERIAL = 72'h0 // serial bytes
) (
	input wire logic clock, // clock
	input wire logic reset_n, // reset
	input wire logic ctl_wr, // control write
	input wire logic [7:0] ctl_rdata, // control reg
	input wire logic [15:0] zptr, // pointer
	input wire logic spm, // store strobe
	input wire logic lpm, // load strobe
	input wire logic [7:0] lpm_data, // load result
	input wire logic lpm_blocked, // load refused
	input wire logic ee_busy // eeprom busy
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic [15:0] run_r;
	logic op_r;
	sequence sig_load(logic [15:0] a);
		lpm && ctl_rdata[SIG_RD_BIT] && ctl_rdata[SPM_EN_BIT] && zptr == a;
	endsequence
	// length of an erase or write, counted from its store strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			run_r <= 16'h0000;
			op_r <= 1'b0;
		end else if (spm && (ctl_rdata[PG_ERASE_BIT] || ctl_rdata[PG_WRITE_BIT])) begin
			run_r <= 16'h0001;
			op_r <= 1'b1;
		end else if (op_r && ctl_rdata[SPM_EN_BIT]) begin
			run_r <= run_r + 16'h0001;
		end else begin
			op_r <= 1'b0;
		end
	end
	a_sig_dev_byte: assert property (sig_load(SIG_DEV0) |=> lpm_data == DEV_ID0)
		else $error("device byte wrong");
	a_sig_cal_byte: assert property (sig_load(SIG_CAL) |=> lpm_data == CAL_BYTE)
		else $error("calibration byte wrong");
	a_sig_serial_order: assert property (sig_load(SIG_SN1) |=> lpm_data == SERIAL[15:8])
		else $error("serial order wrong");
	a_sig_gap_empty: assert property (sig_load(16'h0014) |=> lpm_data == 8'hFF)
		else $error("empty row slot not blank");
	a_arm_self_clear: assert property (ctl_wr ##1 ctl_rdata[SIG_RD_BIT]
		|-> ##[1:4] !ctl_rdata[SIG_RD_BIT] && !ctl_rdata[SPM_EN_BIT])
		else $error("arming bits stuck");
	a_busy_before_rww: assert property (lpm && zptr < 16'h0180 && !ctl_rdata[SIG_RD_BIT]
		|-> !ctl_rdata[RWW_BUSY_BIT])
		else $error("load while section busy");
	a_load_open: assert property (lpm && !ctl_rdata[RWW_BUSY_BIT] |=> !lpm_blocked)
		else $error("load refused while idle");
	a_ee_idle_write: assert property (ctl_wr |-> !ee_busy)
		else $error("control write during eeprom write");
	a_poll_before_cmd: assert property (ctl_wr |-> !ctl_rdata[SPM_EN_BIT])
		else $error("control write before previous op done");
	a_op_length: assert property (op_r && !ctl_rdata[SPM_EN_BIT]
		|-> run_r >= PROG_CYC - 1 && run_r <= PROG_CYC + 2)
		else $error("operation length off");
endmodule

// file: sim/tb_flash_self_program_signature_read.sv
// tb_flash_self_program_signature_read: host and device joined by the link
// assumes register reads answer one cycle after the read strobe
`timescale 1ns/1ns
module tb_flash_self_program_signature_read import fsps_pkg::*;;
	localparam logic [71:0] SN = 72'h998877665544332211;
	localparam int P_CYC = 20;
	localparam logic [7:0] ID0 = 8'hA1;
	localparam logic [7:0] ID1 = 8'hA2;
	localparam logic [7:0] ID2 = 8'hA3;
	localparam logic [7:0] CAL = 8'h5C;
	logic clock, reset_n, wr, rd, ee_act, irq, osc, busy_q;
	logic [7:0] lock_q;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, v;
	int n_mismatch, n_tests;
	// pointer then expected byte
	logic [23:0] sig_t [14] = '{24'h0000A1, 24'h00015C, 24'h0002A2, 24'h0004A3,
		24'h000E22, 24'h000F11, 24'h001044, 24'h001133, 24'h001266, 24'h001355,
		24'h0014FF, 24'h001577, 24'h001688, 24'h001799};
	fsps_if u_fsps_if();
	fsps_dev #(.PROG_CYC(P_CYC), .DEV_ID0(ID0), .DEV_ID1(ID1), .DEV_ID2(ID2),
		.CAL_BYTE(CAL), .SERIAL(SN)) u_fsps_dev (.clock(clock), .reset_n(reset_n),
		.osc_tick(osc), .ee_write_active(ee_act), .link(u_fsps_if.dev),
		.flash_busy(busy_q), .lock_bits(lock_q));
	fsps_host u_fsps_host (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .link(u_fsps_if.host));
	fsps_properties #(.PROG_CYC(P_CYC), .DEV_ID0(ID0), .CAL_BYTE(CAL), .SERIAL(SN))
		u_fsps_properties (.clock(clock), .reset_n(reset_n), .ctl_wr(u_fsps_if.ctl_wr),
		.ctl_rdata(u_fsps_if.ctl_rdata), .zptr(u_fsps_if.zptr), .spm(u_fsps_if.spm),
		.lpm(u_fsps_if.lpm), .lpm_data(u_fsps_if.lpm_data),
		.lpm_blocked(u_fsps_if.lpm_blocked), .ee_busy(u_fsps_if.ee_busy));
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus_wr(logic [3:0] a, logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		v = rdata;
	endtask
	task automatic wait_irq(int b);
		for (int i = 0; i < 400; i++) begin
			bus_rd(HREG_IRQ);
			if (v[b] === 1'b1) return;
		end
		check("irq wait", 16'h0001, 16'h0000);
		close_out();
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		{reset_n, wr, rd, ee_act} = 4'h0;
		osc = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		v = 16'h0000;
		n_mismatch = 0;
		n_tests = 0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		bus_wr(HREG_MASK, 16'h0004);
		for (int i = 0; i < 14; i++) begin
			bus_wr(HREG_ADDR, sig_t[i][23:8]);
			if (i == 0) ee_act <= 1'b1;
			bus_wr(HREG_CMD, {8'h00, HCMD_SIG});
			if (i == 0) begin
				repeat (8) @(posedge clock);
				bus_rd(HREG_IRQ);
				check("done held off", 16'h0000, v & 16'h0004);
				@(posedge clock);
				ee_act <= 1'b0;
			end
			wait_irq(2);
			check("irq raised", 16'h0001, {15'h0000, irq});
			bus_rd(HREG_RDATA);
			check("signature byte", {8'h00, sig_t[i][7:0]}, v);
			bus_wr(HREG_IRQ, 16'h0004);
			@(negedge clock);
			check("irq cleared", 16'h0000, {15'h0000, irq});
		end
		$display("signature test done");
		bus_wr(HREG_MASK, 16'h0000);
		bus_wr(HREG_DATA, 16'h00C3);
		bus_wr(HREG_CMD, {8'h00, HCMD_LOCK});
		wait_irq(2);
		check("irq masked", 16'h0000, {15'h0000, irq});
		@(posedge clock);
		reset_n <= 1'b0;
		@(negedge clock);
		check("busy across reset", 16'h0001, {15'h0000, busy_q});
		@(posedge clock);
		reset_n <= 1'b1;
		repeat (30) @(posedge clock);
		@(negedge clock);
		check("lock bits", 16'h00C3, {8'h00, lock_q});
		check("busy after op", 16'h0000, {15'h0000, busy_q});
		bus_wr(HREG_IRQ, 16'h0007);
		$display("lock test done");
		bus_wr(HREG_DATA, 16'h5A5A);
		bus_wr(HREG_ADDR, 16'h0040);
		bus_wr(HREG_CMD, {8'h00, HCMD_UPDATE});
		v = 16'h0000;
		for (int i = 0; i < 2000 && v[0] !== 1'b1; i++) begin
			bus_rd(HREG_STAT);
			if (v[11:8] === FSPS_H_LOAD) bus_wr(HREG_DATA, 16'h5A5A);
			bus_rd(HREG_IRQ);
		end
		check("update done", 16'h0001, {15'h0000, v[0]});
		check("verify error", 16'h0000, {15'h0000, v[1]});
		$display("update test done");
		close_out();
	end
endmodule
